// file: design/link_mode_pkg.sv
// Constants for the serial link mode and test control block.
package link_mode_pkg;
    localparam logic [11:0] ADDR_SYNC_CODING  = 12'h572;
    localparam logic [11:0] ADDR_SUM_TEST     = 12'h573;
    localparam logic [11:0] ADDR_ALIGN_DELAY  = 12'h574;
    localparam logic [11:0] ADDR_PHASE_OFFSET = 12'h578;
    localparam logic [11:0] ADDR_DEVICE_ID    = 12'h580;
    localparam logic [7:0]  RESET_VALUE       = 8'h00;
    // Field positions.
    localparam int SYNC_MODE_HI  = 7;
    localparam int SYNC_MODE_LO  = 6;
    localparam int SYNC_INV_BIT  = 5;
    localparam int SYNC_TYPE_BIT = 4;
    localparam int BYPASS_BIT    = 2;
    localparam int BIT_INV_BIT   = 1;
    localparam int SUM_MODE_HI   = 7;
    localparam int SUM_MODE_LO   = 6;
    localparam int INJ_HI        = 5;
    localparam int INJ_LO        = 4;
    localparam int PAT_HI        = 3;
    localparam int PAT_LO        = 0;
    localparam int DLY_HI        = 7;
    localparam int DLY_LO        = 4;
    localparam int LTEST_HI      = 2;
    localparam int LTEST_LO      = 0;
    localparam logic [1:0] SYNC_NORMAL     = 2'h0;
    localparam logic [1:0] SYNC_FORCE_CGS  = 2'h2;
    localparam logic [1:0] SYNC_FORCE_ILAS = 2'h3;
    localparam logic [1:0] SUM_REGS        = 2'h0;
    localparam logic [1:0] SUM_FIELDS      = 2'h1;
    localparam logic [1:0] INJ_SAMPLE      = 2'h0;
    localparam logic [1:0] INJ_ENCODED     = 2'h1;
    localparam logic [3:0] PAT_NORMAL      = 4'h0;
    localparam logic [3:0] PAT_CHECKER     = 4'h1;
    localparam logic [3:0] PAT_TOGGLE      = 4'h2;
    localparam logic [3:0] PAT_PN31        = 4'h3;
    localparam logic [3:0] PAT_PN23        = 4'h4;
    localparam logic [3:0] PAT_PN15        = 4'h5;
    localparam logic [3:0] PAT_PN9         = 4'h6;
    localparam logic [3:0] PAT_USER_REPEAT = 4'he;
    localparam logic [3:0] PAT_USER_ONCE   = 4'hf;
    localparam logic [31:0] PN_SEED        = 32'hffffffff;
    typedef enum logic [1:0] {
        ST_CGS  = 2'b00,
        ST_WAIT = 2'b01,
        ST_ILAS = 2'b11,
        ST_DATA = 2'b10
    } link_state_t;
endpackage

// file: design/pattern_source.sv
// Test word generator: fixed patterns, PN sequences and user pattern.
`timescale 1ns/10ps
module pattern_source
    import link_mode_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_adv,
    input  wire logic [3:0]   i_pattern,
    input  wire logic [W-1:0] i_user_word,
    input  wire logic         i_user_last,
    output logic              o_user_done,
    output logic [W-1:0]      o_word
);
    logic [30:0]  lfsr_q, lfsr_d;
    logic         phase_q, phase_d;
    logic         done_q, done_d;
    logic [3:0]   pat_q, pat_d;
    logic [W-1:0] word_q, word_d;

    // Advances a Fibonacci register of length len with taps at len and tap.
    function automatic logic [30:0] pn_step(input logic [30:0] s, input int len, input int tap);
        logic [30:0] r;
        logic        fb;
        r  = s;
        fb = s[len-1] ^ s[tap-1];
        r  = {s[29:0], fb};
        r  = r & ((31'h1 << len) - 31'h1);
        return r;
    endfunction

    always_comb begin
        lfsr_d  = lfsr_q;
        phase_d = phase_q;
        done_d  = done_q;
        pat_d   = i_pattern;
        word_d  = word_q;
        if (pat_q != i_pattern) begin
            lfsr_d  = PN_SEED[30:0];
            done_d  = 1'b0;
            phase_d = 1'b0;
        end else if (i_adv) begin
            phase_d = ~phase_q;
            unique case (i_pattern)
                PAT_CHECKER: word_d = phase_q ? {(W/2){2'b10}} : {(W/2){2'b01}};
                PAT_TOGGLE:  word_d = phase_q ? '1 : '0;
                PAT_PN31: begin
                    lfsr_d = pn_step(lfsr_q, 31, 28);
                    word_d = W'(lfsr_q);
                end
                PAT_PN23: begin
                    lfsr_d = pn_step(lfsr_q, 23, 18);
                    word_d = W'(lfsr_q);
                end
                PAT_PN15: begin
                    lfsr_d = pn_step(lfsr_q, 15, 14);
                    word_d = W'(lfsr_q);
                end
                PAT_PN9: begin
                    lfsr_d = pn_step(lfsr_q, 9, 5);
                    word_d = W'(lfsr_q);
                end
                PAT_USER_REPEAT: word_d = i_user_word;
                PAT_USER_ONCE: begin
                    word_d = done_q ? '0 : i_user_word;
                    if (i_user_last)
                        done_d = 1'b1;
                end
                default: word_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lfsr_q  <= PN_SEED[30:0];
            phase_q <= 1'b0;
            done_q  <= 1'b0;
            pat_q   <= PAT_NORMAL;
            word_q  <= '0;
        end else begin
            lfsr_q  <= lfsr_d;
            phase_q <= phase_d;
            done_q  <= done_d;
            pat_q   <= pat_d;
            word_q  <= word_d;
        end
    end

    assign o_word      = word_q;
    assign o_user_done = done_q;
endmodule // pattern_source

// file: design/serial_link_mode_test_control.sv
// Link mode registers, sync handling, alignment start and test data injection.
`timescale 1ns/10ps

module serial_link_mode_test_control
    import link_mode_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    input  wire logic [11:0]  i_addr,
    input  wire logic [7:0]   i_wdata,
    output logic [7:0]        o_rdata,
    input  wire logic [4:0]   i_frames_field,
    input  wire logic [7:0]   i_cfg_reg_sum,
    input  wire logic [7:0]   i_cfg_field_sum,
    input  wire logic         i_sync_request_input,
    input  wire logic         i_frame_tick,
    input  wire logic [W-1:0] i_sample,
    input  wire logic [9:0]   i_enc_word,
    input  wire logic [W-1:0] i_user_word,
    input  wire logic         i_user_last,
    output logic [7:0]        o_checksum,
    output logic [W-1:0]      o_sample,
    output logic [9:0]        o_enc_word,
    output logic              o_send_cgs,
    output logic              o_send_ilas,
    output logic              o_send_data,
    output logic              o_sync_cmos,
    output logic              o_coding_bypass,
    output logic              o_coding_invert,
    output logic [2:0]        o_link_test,
    output logic [7:0]        o_phase_offset,
    output logic [7:0]        o_device_id,
    output logic              o_multiframe_edge,
    output logic              o_user_done
);
    logic [7:0] sync_input_and_coding_control_q, sync_input_and_coding_control_d;
    logic [7:0] checksum_and_test_pattern_select_q, checksum_and_test_pattern_select_d;
    logic [7:0] alignment_delay_and_link_test_q, alignment_delay_and_link_test_d;
    logic [7:0] multiframe_phase_offset_q, multiframe_phase_offset_d;
    logic [7:0] link_device_identifier_q, link_device_identifier_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] checksum_q, checksum_d;
    logic [W-1:0] sample_q, sample_d;
    logic [9:0]   enc_q, enc_d;
    logic       sync_m_q, sync_s_q;
    logic       req_q, req_d;
    logic [4:0] frame_cnt_q, frame_cnt_d;
    logic [3:0] mf_cnt_q, mf_cnt_d;
    link_state_t state_q, state_d;
    logic       mf_edge;
    logic       req_raw;
    logic       test_on;
    logic [1:0] sync_mode;
    logic [W-1:0] test_word;

    assign sync_mode = sync_input_and_coding_control_q[SYNC_MODE_HI:SYNC_MODE_LO];
    assign test_on   = checksum_and_test_pattern_select_q[PAT_HI:PAT_LO] != PAT_NORMAL;

    pattern_source #(.W(W)) u_pattern (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_adv       (i_frame_tick),
        .i_pattern   (checksum_and_test_pattern_select_q[PAT_HI:PAT_LO]),
        .i_user_word (i_user_word),
        .i_user_last (i_user_last),
        .o_user_done (o_user_done),
        .o_word      (test_word)
    );

    // Register writes and read-back.
    always_comb begin
        sync_input_and_coding_control_d    = sync_input_and_coding_control_q;
        checksum_and_test_pattern_select_d = checksum_and_test_pattern_select_q;
        alignment_delay_and_link_test_d    = alignment_delay_and_link_test_q;
        multiframe_phase_offset_d          = multiframe_phase_offset_q;
        link_device_identifier_d           = link_device_identifier_q;
        rdata_d                            = rdata_q;
        if (i_wr) begin
            unique case (i_addr)
                ADDR_SYNC_CODING:  sync_input_and_coding_control_d    = i_wdata & 8'hf6;
                ADDR_SUM_TEST:     checksum_and_test_pattern_select_d = i_wdata;
                ADDR_ALIGN_DELAY:  alignment_delay_and_link_test_d    = i_wdata & 8'hf7;
                ADDR_PHASE_OFFSET: multiframe_phase_offset_d          = i_wdata & 8'h1f;
                ADDR_DEVICE_ID:    link_device_identifier_d           = i_wdata;
                default: ;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                ADDR_SYNC_CODING:  rdata_d = sync_input_and_coding_control_q;
                ADDR_SUM_TEST:     rdata_d = checksum_and_test_pattern_select_q;
                ADDR_ALIGN_DELAY:  rdata_d = alignment_delay_and_link_test_q;
                ADDR_PHASE_OFFSET: rdata_d = multiframe_phase_offset_q;
                ADDR_DEVICE_ID:    rdata_d = link_device_identifier_q;
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    // Checksum, injection and alignment sequencing.
    always_comb begin
        unique case (checksum_and_test_pattern_select_q[SUM_MODE_HI:SUM_MODE_LO])
            SUM_REGS:   checksum_d = i_cfg_reg_sum;
            SUM_FIELDS: checksum_d = i_cfg_field_sum;
            default:    checksum_d = i_cfg_reg_sum;
        endcase
        sample_d = i_sample;
        enc_d    = i_enc_word;
        if (test_on) begin
            unique case (checksum_and_test_pattern_select_q[INJ_HI:INJ_LO])
                INJ_SAMPLE:  sample_d = test_word;
                INJ_ENCODED: enc_d    = test_word[9:0];
                default:     sample_d = test_word;
            endcase
        end
        // Polarity bit 0 means the request is asserted low.
        req_raw = sync_input_and_coding_control_q[SYNC_INV_BIT] ? sync_s_q : ~sync_s_q;
        req_d   = req_raw;
        mf_edge = i_frame_tick && (frame_cnt_q == i_frames_field);
        frame_cnt_d = frame_cnt_q;
        if (i_frame_tick)
            frame_cnt_d = mf_edge ? 5'h00 : frame_cnt_q + 5'h01;
        mf_cnt_d = mf_cnt_q;
        state_d  = state_q;
        unique case (state_q)
            ST_CGS: begin
                mf_cnt_d = 4'h0;
                if (!req_q)
                    state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (req_q)
                    state_d = ST_CGS;
                else if (mf_edge) begin
                    if (mf_cnt_q == alignment_delay_and_link_test_q[DLY_HI:DLY_LO])
                        state_d = ST_ILAS;
                    else
                        mf_cnt_d = mf_cnt_q + 4'h1;
                end
            end
            ST_ILAS: begin
                if (req_q)
                    state_d = ST_CGS;
                else if (mf_edge)
                    state_d = ST_DATA;
            end
            ST_DATA: begin
                if (req_q)
                    state_d = ST_CGS;
            end
        endcase
        // Ignore modes hold the sequencer in the forced state.
        if (sync_mode == SYNC_FORCE_CGS)
            state_d = ST_CGS;
        else if (sync_mode == SYNC_FORCE_ILAS)
            state_d = ST_ILAS;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sync_input_and_coding_control_q    <= RESET_VALUE;
            checksum_and_test_pattern_select_q <= RESET_VALUE;
            alignment_delay_and_link_test_q    <= RESET_VALUE;
            multiframe_phase_offset_q          <= RESET_VALUE;
            link_device_identifier_q           <= RESET_VALUE;
            rdata_q     <= 8'h00;
            checksum_q  <= 8'h00;
            sample_q    <= '0;
            enc_q       <= 10'h000;
            sync_m_q    <= 1'b1;
            sync_s_q    <= 1'b1;
            req_q       <= 1'b1;
            frame_cnt_q <= 5'h00;
            mf_cnt_q    <= 4'h0;
            state_q     <= ST_CGS;
        end else begin
            sync_input_and_coding_control_q    <= sync_input_and_coding_control_d;
            checksum_and_test_pattern_select_q <= checksum_and_test_pattern_select_d;
            alignment_delay_and_link_test_q    <= alignment_delay_and_link_test_d;
            multiframe_phase_offset_q          <= multiframe_phase_offset_d;
            link_device_identifier_q           <= link_device_identifier_d;
            rdata_q     <= rdata_d;
            checksum_q  <= checksum_d;
            sample_q    <= sample_d;
            enc_q       <= enc_d;
            sync_m_q    <= i_sync_request_input;
            sync_s_q    <= sync_m_q;
            req_q       <= req_d;
            frame_cnt_q <= frame_cnt_d;
            mf_cnt_q    <= mf_cnt_d;
            state_q     <= state_d;
        end
    end

    assign o_rdata           = rdata_q;
    assign o_checksum        = checksum_q;
    assign o_sample          = sample_q;
    assign o_enc_word        = enc_q;
    assign o_send_cgs        = state_q == ST_CGS || state_q == ST_WAIT;
    assign o_send_ilas       = state_q == ST_ILAS;
    assign o_send_data       = state_q == ST_DATA;
    assign o_sync_cmos       = sync_input_and_coding_control_q[SYNC_TYPE_BIT];
    assign o_coding_bypass   = sync_input_and_coding_control_q[BYPASS_BIT];
    assign o_coding_invert   = sync_input_and_coding_control_q[BIT_INV_BIT];
    assign o_link_test       = alignment_delay_and_link_test_q[LTEST_HI:LTEST_LO];
    assign o_phase_offset    = multiframe_phase_offset_q;
    assign o_device_id       = link_device_identifier_q;
    assign o_multiframe_edge = mf_edge;
endmodule // serial_link_mode_test_control

// file: testbench/link_mode_props.sv
// Port assertions for the link mode and test control block.
`timescale 1ns/10ps
module link_mode_props
    import link_mode_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic         i_clk,
    input wire logic         i_rst_n,
    input wire logic         i_wr,
    input wire logic         i_rd,
    input wire logic [11:0]  i_addr,
    input wire logic [7:0]   i_wdata,
    input wire logic [7:0]   o_rdata,
    input wire logic [7:0]   i_cfg_reg_sum,
    input wire logic [7:0]   i_cfg_field_sum,
    input wire logic         i_sync_request_input,
    input wire logic         i_frame_tick,
    input wire logic [W-1:0] i_sample,
    input wire logic [W-1:0] o_sample,
    input wire logic [7:0]   o_checksum,
    input wire logic         o_send_cgs,
    input wire logic         o_send_ilas,
    input wire logic         o_send_data,
    input wire logic         o_multiframe_edge,
    input wire logic         o_user_done
);
    logic [7:0] mode_q;
    logic [7:0] sum_q;
    // Shadow copies of the two control registers, updated on the same edge as the design's.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mode_q <= 8'h00;
            sum_q  <= 8'h00;
        end else if (i_wr && i_addr == ADDR_SYNC_CODING) begin
            mode_q <= i_wdata & 8'hf6;
        end else if (i_wr && i_addr == ADDR_SUM_TEST) begin
            sum_q <= i_wdata;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_sum_regs: assert property ($past(i_rst_n) && $past(sum_q[7:6]) == SUM_REGS |-> o_checksum == $past(i_cfg_reg_sum))
        else $error("checksum does not follow register sum");
    a_sum_fields: assert property ($past(i_rst_n) && $past(sum_q[7:6]) == SUM_FIELDS |-> o_checksum == $past(i_cfg_field_sum))
        else $error("checksum does not follow field sum");
    a_normal_pass: assert property ($past(i_rst_n) && $past(sum_q[3:0]) == PAT_NORMAL |-> o_sample == $past(i_sample))
        else $error("normal data not passed to sample output");
    a_encoded_inject: assert property ($past(i_rst_n) && $past(sum_q[5:4]) == INJ_ENCODED |-> o_sample == $past(i_sample))
        else $error("sample path altered while injecting at encoder");
    a_force_cgs: assert property ((mode_q[7:6] == SYNC_FORCE_CGS)[*4] |-> o_send_cgs && !o_send_ilas)
        else $error("forced code group sync not sent");
    a_force_ilas: assert property ((mode_q[7:6] == SYNC_FORCE_ILAS)[*4] |-> o_send_ilas && !o_send_cgs)
        else $error("forced alignment sequence not sent");
    a_request_cgs: assert property ((mode_q[7:5] == 3'b000 && !i_sync_request_input)[*5] |-> o_send_cgs)
        else $error("sync request not answered with code groups");
    a_ilas_on_edge: assert property ($rose(o_send_ilas) && mode_q[7:6] == SYNC_NORMAL |-> $past(o_multiframe_edge))
        else $error("alignment started off a multiframe boundary");
    a_edge_on_tick: assert property (o_multiframe_edge |-> i_frame_tick)
        else $error("multiframe edge without frame tick");
    a_one_state: assert property ($onehot0({o_send_cgs, o_send_ilas, o_send_data}))
        else $error("more than one link state output high");
    a_rdata_hold: assert property ($past(i_rst_n) && !$past(i_rd) |-> $stable(o_rdata))
        else $error("read data changed without a read");
    c_ilas: cover property ($rose(o_send_ilas));
    c_data: cover property ($rose(o_send_data));
    c_done: cover property ($rose(o_user_done));
endmodule // link_mode_props

bind serial_link_mode_test_control link_mode_props #(.W(W)) link_mode_props_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_cfg_reg_sum(i_cfg_reg_sum), .i_cfg_field_sum(i_cfg_field_sum),
    .i_sync_request_input(i_sync_request_input), .i_frame_tick(i_frame_tick), .i_sample(i_sample),
    .o_sample(o_sample), .o_checksum(o_checksum), .o_send_cgs(o_send_cgs), .o_send_ilas(o_send_ilas),
    .o_send_data(o_send_data), .o_multiframe_edge(o_multiframe_edge), .o_user_done(o_user_done)
);

// file: testbench/link_receiver_model.sv
// Receiver model: drives the sync request pin and the frame tick.
`timescale 1ns/10ps
module link_receiver_model (
    input  wire logic i_clk,
    input  wire logic i_release,
    output logic      o_sync_request_input,
    output logic      o_frame_tick
);
    logic div_q;
    initial begin
        div_q = 1'b0;
        o_sync_request_input = 1'b0;
        o_frame_tick = 1'b0;
    end
    // The request is held low until the bench lets the receiver release it.
    always @(negedge i_clk) begin
        o_sync_request_input <= i_release;
        div_q <= ~div_q;
        o_frame_tick <= div_q;
    end
endmodule // link_receiver_model

// file: testbench/tb.sv
// Self-checking testbench for the link mode and test control block.
`timescale 1ns/10ps
module tb;
    import link_mode_pkg::*;
    typedef struct {int kind; logic [15:0] val; string nm;} exp_t;
    logic        i_clk, i_rst_n, i_wr, i_rd, i_sync_request_input, i_frame_tick, i_user_last, rel, look;
    logic [11:0] i_addr;
    logic [7:0]  i_wdata, o_rdata, i_cfg_reg_sum, i_cfg_field_sum, o_checksum, o_phase_offset, o_device_id;
    logic [2:0]  o_link_test;
    logic        o_sync_cmos, o_coding_bypass, o_coding_invert;
    logic [4:0]  i_frames_field;
    logic [15:0] i_sample, i_user_word, o_sample, got;
    logic [9:0]  i_enc_word, o_enc_word;
    logic        o_send_cgs, o_send_ilas, o_send_data, o_multiframe_edge, o_user_done, rd_took, seen;
    logic [31:0] seed;
    int          bad_count, cmp_count, cnt, tk, k;
    exp_t        q[$];
    exp_t        e;
    logic [11:0] addrs[5] = '{ADDR_SYNC_CODING, ADDR_SUM_TEST, ADDR_ALIGN_DELAY, ADDR_PHASE_OFFSET, ADDR_DEVICE_ID};
    logic [7:0]  wv[5] = '{8'hff, 8'hff, 8'hff, 8'ha5, 8'h3c};
    logic [7:0]  rv[5] = '{8'hf6, 8'hff, 8'hf7, 8'h05, 8'h3c};
    // Second test word after a pattern change, from an all-ones start.
    logic [15:0] pv[7] = '{16'h0000, 16'h0000, 16'hffff, 16'h03fe, 16'hfffe, 16'h03fe, 16'h01fe};

    serial_link_mode_test_control #(.W(16)) serial_link_mode_test_control_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .i_frames_field(i_frames_field), .i_cfg_reg_sum(i_cfg_reg_sum),
        .i_cfg_field_sum(i_cfg_field_sum), .i_sync_request_input(i_sync_request_input),
        .i_frame_tick(i_frame_tick), .i_sample(i_sample), .i_enc_word(i_enc_word), .i_user_word(i_user_word),
        .i_user_last(i_user_last), .o_checksum(o_checksum), .o_sample(o_sample), .o_enc_word(o_enc_word),
        .o_send_cgs(o_send_cgs), .o_send_ilas(o_send_ilas), .o_send_data(o_send_data),
        .o_sync_cmos(o_sync_cmos), .o_coding_bypass(o_coding_bypass), .o_coding_invert(o_coding_invert),
        .o_link_test(o_link_test), .o_phase_offset(o_phase_offset), .o_device_id(o_device_id),
        .o_multiframe_edge(o_multiframe_edge), .o_user_done(o_user_done)
    );
    link_receiver_model link_receiver_model_inst (
        .i_clk(i_clk), .i_release(rel), .o_sync_request_input(i_sync_request_input), .o_frame_tick(i_frame_tick)
    );

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] seen_v);
        cmp_count++;
        if (seen_v !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen_v);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge i_clk);
        {i_addr, i_wdata, i_wr} = {a, d, 1'b1};
        @(negedge i_clk);
        i_wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] ex);
        @(negedge i_clk);
        {i_addr, i_rd} = {a, 1'b1};
        q.push_back('{0, {8'h00, ex}, $sformatf("read %h", a)});
        @(negedge i_clk);
        i_rd = 1'b0;
    endtask
    // Notes an expected output value; the monitor compares it a few ns later.
    task automatic expect_out(input int kind, input logic [15:0] v, input string nm);
        q.push_back('{kind, v, nm});
        look = 1'b1;
        #6;
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge i_clk) rd_took <= i_rd;
    always @(negedge i_clk) begin
        #5;
        if ((rd_took || look) && q.size() > 0) begin
            e = q.pop_front();
            case (e.kind)
                0: got = {8'h00, o_rdata};
                1: got = o_sample;
                2: got = {8'h00, o_checksum};
                4: got = {13'h0000, o_send_cgs, o_send_ilas, o_send_data};
                5: got = {6'h00, o_enc_word};
                6: got = {o_device_id, o_phase_offset};
                7: got = {10'h000, o_sync_cmos, o_coding_bypass, o_coding_invert, o_link_test};
                default: got = {15'h0000, o_user_done};
            endcase
            check(e.nm, e.val, got);
            look = 1'b0;
        end
    end
    always @(negedge i_clk) begin
        {i_sample, i_user_word} <= rnd();
        i_enc_word <= seed[25:16];
    end
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        close_out();
    end

    initial begin
        seed = 32'h00000047;
        {i_rst_n, i_wr, i_rd, i_user_last, rel, look, bad_count, cmp_count} = '0;
        {i_addr, i_wdata, i_cfg_reg_sum, i_cfg_field_sum, i_frames_field} = '0;
        {i_sample, i_user_word, i_enc_word} = '0;
        repeat (8) @(negedge i_clk);
        i_rst_n = 1'b1;
        for (k = 0; k < 5; k++) rd(addrs[k], RESET_VALUE);
        for (k = 0; k < 5; k++) wr(addrs[k], wv[k]);
        wr(12'h575, 8'hff);
        expect_out(6, 16'h3c05, "id and phase offset");
        @(negedge i_clk);
        expect_out(7, 16'h003f, "sync type and coding fields");
        for (k = 0; k < 5; k++) rd(addrs[k], rv[k]);
        rd(12'h575, 8'h00);
        for (k = 0; k < 5; k++) wr(addrs[k], 8'h00);
        $display("registers test done");
        for (k = 0; k < 2; k++) begin
            {i_cfg_reg_sum, i_cfg_field_sum} = 16'(rnd());
            wr(ADDR_SUM_TEST, 8'(k << 6));
            @(negedge i_clk);
            expect_out(2, {8'h00, (k == 1) ? i_cfg_field_sum : i_cfg_reg_sum}, "checksum");
        end
        wr(ADDR_SUM_TEST, {4'h0, PAT_CHECKER});
        @(negedge i_clk);
        for (k = 0; k < 2; k++) begin
            do @(negedge i_clk); while (i_frame_tick !== 1'b1);
            @(negedge i_clk);
            expect_out(1, (k == 1) ? 16'haaaa : 16'h5555, "checkerboard");
        end
        for (k = 2; k < 7; k++) begin
            wr(ADDR_SUM_TEST, 8'(k + 16 * (k % 2)));
            @(negedge i_clk);
            repeat (2) do @(negedge i_clk); while (i_frame_tick !== 1'b1);
            @(negedge i_clk);
            expect_out((k % 2) ? 5 : 1, pv[k], "test word");
        end
        i_user_last = 1'b1;
        wr(ADDR_SUM_TEST, {4'h0, PAT_USER_REPEAT});
        repeat (20) @(negedge i_clk);
        expect_out(3, 16'h0000, "repeat done flag");
        wr(ADDR_SUM_TEST, {4'h0, PAT_USER_ONCE});
        for (k = 0; k < 20 && o_user_done !== 1'b1; k++) @(negedge i_clk);
        expect_out(3, 16'h0001, "single done flag");
        repeat (4) @(negedge i_clk);
        expect_out(1, 16'h0000, "after single pattern");
        wr(ADDR_SUM_TEST, 8'h00);
        $display("pattern test done");
        for (k = 0; k < 2; k++) begin
            i_frames_field = 5'(rnd() % 4);
            wr(ADDR_ALIGN_DELAY, (k == 1) ? 8'hf0 : 8'h00);
            rel = 1'b0;
            repeat (10) @(negedge i_clk);
            expect_out(4, 16'h0004, "request state");
            {cnt, tk, seen, rel} = {32'h0, 32'h0, 1'b0, 1'b1};
            for (int n = 0; n < 800 && o_send_ilas !== 1'b1; n++) begin
                @(negedge i_clk);
                #20;
                if (n >= 4 && o_multiframe_edge && o_send_cgs) cnt++;
                if (i_frame_tick) tk++;
                if (o_multiframe_edge) begin
                    if (seen) check("frames per multiframe", 16'(i_frames_field + 1), 16'(tk));
                    {tk, seen} = {32'h0, 1'b1};
                end
            end
            check("alignment boundary", (k == 1) ? 16'h0010 : 16'h0001, 16'(cnt));
            repeat (20) @(negedge i_clk);
            expect_out(4, 16'h0001, "data after alignment");
        end
        wr(ADDR_SYNC_CODING, {SYNC_FORCE_CGS, 6'h00});
        repeat (6) @(negedge i_clk);
        expect_out(4, 16'h0004, "forced cgs");
        wr(ADDR_SYNC_CODING, {SYNC_FORCE_ILAS, 6'h00});
        repeat (6) @(negedge i_clk);
        expect_out(4, 16'h0002, "forced ilas");
        wr(ADDR_ALIGN_DELAY, 8'h00);
        wr(ADDR_SYNC_CODING, 8'h20);
        repeat (6) @(negedge i_clk);
        expect_out(4, 16'h0004, "inverted request");
        rel = 1'b0;
        repeat (40) @(negedge i_clk);
        expect_out(4, 16'h0001, "inverted release");
        $display("sync test done");
        close_out();
    end
endmodule // tb
